// ---- include/pmt_pkg.sv ----
package pmt_pkg;
  // ----------------------------------------
  // Link register indices
  // ----------------------------------------
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RMASK = 3'h1;
  localparam logic [2:0] ADDR_BMASK = 3'h2;
  localparam logic [2:0] ADDR_PROBE = 3'h3;
  localparam logic [2:0] ADDR_PAL = 3'h4;
  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int CTRL_OV0_SHOW = 0;
  localparam int CTRL_OV1_SHOW = 1;
  localparam int CTRL_OV0_BLINK = 2;
  localparam int CTRL_OV1_BLINK = 3;
  localparam int CTRL_RATE_LSB = 4;
  // ----------------------------------------
  // Probe field positions
  // ----------------------------------------
  localparam int PROBE_RED = 0;
  localparam int PROBE_GREEN = 1;
  localparam int PROBE_BLUE = 2;
  localparam int PROBE_LOW_NIB = 3;
  // ----------------------------------------
  // Blink rates in retrace intervals
  // ----------------------------------------
  localparam logic [1:0] RATE_16_48 = 2'h0;
  localparam logic [1:0] RATE_16_16 = 2'h1;
  localparam logic [1:0] RATE_32_32 = 2'h2;
  localparam logic [1:0] RATE_64_64 = 2'h3;
  localparam logic [6:0] ON_16 = 7'h10;
  localparam logic [6:0] ON_32 = 7'h20;
  localparam logic [6:0] ON_64 = 7'h40;
  localparam logic [6:0] MOD_32 = 7'h1f;
  localparam logic [6:0] MOD_64 = 7'h3f;
  localparam logic [6:0] MOD_128 = 7'h7f;
  localparam logic [1:0] TRIPLET_LAST = 2'h2;
  // ----------------------------------------
  // Device variants
  // ----------------------------------------
  typedef enum logic [1:0] {VAR_RGB8, VAR_RGB4, VAR_MONO8} pmt_variant_type;
  // ----------------------------------------
  // Controller Avalon map (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] AV_DEV_BASE = 6'h00;
  localparam logic [5:0] AV_DEV_LAST = 6'h10;
  localparam logic [5:0] AV_STATUS = 6'h20;
  localparam logic [5:0] AV_HOLD = 6'h24;
  localparam int ST_DRIVEN = 0;
  localparam int ST_FREEZE = 1;
endpackage

// ---- include/pmt_link_if.sv ----
`timescale 1ns/1ps
interface pmt_link_if;
  logic sel_n;
  logic rd;
  logic wr;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rdrv;
  logic ack;
  modport dev (
    input sel_n,
    input rd,
    input wr,
    input addr,
    input wdata,
    output rdata,
    output rdrv,
    output ack
  );
  modport host (
    output sel_n,
    output rd,
    output wr,
    output addr,
    output wdata,
    input rdata,
    input rdrv,
    input ack
  );
endinterface

// ---- src/pmt_dev.sv ----
// Functional notes
// - Overlay 1 zeroed when its show bit clear
// - Overlay 0 zeroed when its show bit clear
// - Read mask ANDed with pixel planes
// - Mask and probe registers unreset, host initialises
// - Blink mask bit makes plane blink
// - Plane blinks only if read mask set
// - Probe write keeps only low nibble
// - Probe bits: nibble select, blue, green, red
// - Probe read: DAC nibble high, settings low
// - Host sets one colour enable before probing
// - Host keeps pixel inputs steady during probe
// - Four-bit variant reads bit 3 as zero
// - Mono variant echoes written low nibble
// - Mono, no enables: byte per palette access
// - Mono, enable set: act only on its triplet slot
// - Host holds select low over whole triplet
// - Blink rate field chooses on/off retrace counts
// - Overlay blink toggles input with zero
`timescale 1ns/1ps
module pmt_dev #(
  parameter pmt_pkg::pmt_variant_type VARIANT = pmt_pkg::VAR_RGB8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Bus link
  pmt_link_if.dev link,
  // Frame timing pin
  input wire logic vretrace_i,
  // Pixel inputs
  input wire logic [7:0] pixel_index_planes_i,
  input wire logic overlay_plane1_in_i,
  input wire logic overlay_plane0_in_i,
  // Gated pixel outputs
  output logic [7:0] palette_index_o,
  output logic overlay1_o,
  output logic overlay0_o,
  // DAC input data
  input wire logic [7:0] dac_red_i,
  input wire logic [7:0] dac_green_i,
  input wire logic [7:0] dac_blue_i,
  // Palette data port
  output logic pal_wr_o,
  output logic pal_rd_o,
  output logic [7:0] pal_wdata_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pixel_path_control_ff, plane_read_mask_ff, plane_blink_mask_ff;
  logic [3:0] probe_ff;
  logic busy_ff, ack_ff, rdrv_ff, pal_wr_ff, pal_rd_ff, ov1_ff, ov0_ff, vr_rise_seen_ff;
  logic [7:0] rdata_ff, pal_wdata_ff, index_ff;
  logic [1:0] slot_ff;
  logic [2:0] vr_sync_ff;
  logic [6:0] frame_cnt_ff;
  logic take, take_wr, take_rd, is_mono, triplet_mode, slot_hit;
  logic [1:0] rate;
  logic blink_on, nxt_rdrv, vr_rise;
  logic [7:0] dac_sel, nxt_rdata;
  logic [3:0] nibble, probe_low;
  assign is_mono = (VARIANT == pmt_pkg::VAR_MONO8);
  assign triplet_mode = is_mono && (probe_ff[2:0] != 3'h0);
  // ----------------------------------------
  // Request taking
  // ----------------------------------------
  assign take = !link.sel_n && (link.rd || link.wr) && !busy_ff;
  assign take_wr = take && link.wr;
  assign take_rd = take && link.rd;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      busy_ff <= 1'b0;
    else if (take)
      busy_ff <= 1'b1;
    else if (!(link.rd || link.wr))
      busy_ff <= 1'b0;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= take;
  end
  // ----------------------------------------
  // Register writes, no reset
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (take_wr && link.addr == pmt_pkg::ADDR_CTRL)
      pixel_path_control_ff <= link.wdata;
    else if (take_wr && link.addr == pmt_pkg::ADDR_RMASK)
      plane_read_mask_ff <= link.wdata;
    else if (take_wr && link.addr == pmt_pkg::ADDR_BMASK)
      plane_blink_mask_ff <= link.wdata;
    else if (take_wr && link.addr == pmt_pkg::ADDR_PROBE)
      probe_ff <= link.wdata[3:0];
  end
  // ----------------------------------------
  // Triplet slot tracking
  // ----------------------------------------
  assign slot_hit = probe_ff[slot_ff];
  always_ff @(posedge clk_i)
  begin
    if (srst_i || link.sel_n)
      slot_ff <= 2'h0;
    else if (take_wr && link.addr == pmt_pkg::ADDR_PROBE)
      slot_ff <= 2'h0;
    else if (take && link.addr == pmt_pkg::ADDR_PAL && triplet_mode)
      slot_ff <= (slot_ff == pmt_pkg::TRIPLET_LAST) ? 2'h0 : slot_ff + 2'h1;
  end
  // ----------------------------------------
  // Palette port strobes
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pal_wr_ff <= 1'b0;
      pal_rd_ff <= 1'b0;
      pal_wdata_ff <= 8'h00;
    end
    else
    begin
      pal_wr_ff <= take_wr && link.addr == pmt_pkg::ADDR_PAL
        && (!triplet_mode || slot_hit);
      pal_rd_ff <= take_rd && link.addr == pmt_pkg::ADDR_PAL
        && (!triplet_mode || slot_hit);
      if (take_wr && link.addr == pmt_pkg::ADDR_PAL)
        pal_wdata_ff <= link.wdata;
    end
  end
  assign pal_wr_o = pal_wr_ff;
  assign pal_rd_o = pal_rd_ff;
  assign pal_wdata_o = pal_wdata_ff;
  // ----------------------------------------
  // Probe read data
  // ----------------------------------------
  always_comb
  begin
    if (is_mono || probe_ff[pmt_pkg::PROBE_RED])
      dac_sel = dac_red_i;
    else if (probe_ff[pmt_pkg::PROBE_GREEN])
      dac_sel = dac_green_i;
    else if (probe_ff[pmt_pkg::PROBE_BLUE])
      dac_sel = dac_blue_i;
    else
      dac_sel = 8'h00;
  end

  always_comb
  begin
    if (VARIANT == pmt_pkg::VAR_RGB4)
    begin
      nibble = dac_sel[7:4];
      probe_low = {1'b0, probe_ff[2:0]};
    end
    else
    begin
      nibble = probe_ff[pmt_pkg::PROBE_LOW_NIB] ? dac_sel[3:0] : dac_sel[7:4];
      probe_low = probe_ff;
    end
  end

  always_comb
  begin
    nxt_rdata = 8'h00;
    nxt_rdrv = 1'b1;
    if (link.addr == pmt_pkg::ADDR_CTRL)
      nxt_rdata = pixel_path_control_ff;
    else if (link.addr == pmt_pkg::ADDR_RMASK)
      nxt_rdata = plane_read_mask_ff;
    else if (link.addr == pmt_pkg::ADDR_BMASK)
      nxt_rdata = plane_blink_mask_ff;
    else if (link.addr == pmt_pkg::ADDR_PROBE)
      nxt_rdata = {nibble, probe_low};
    else if (link.addr == pmt_pkg::ADDR_PAL)
    begin
      nxt_rdata = dac_sel;
      nxt_rdrv = !triplet_mode || slot_hit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_ff <= 8'h00;
      rdrv_ff <= 1'b0;
    end
    else if (take_rd)
    begin
      rdata_ff <= nxt_rdrv ? nxt_rdata : 8'h00;
      rdrv_ff <= nxt_rdrv;
    end
    else if (take_wr)
      rdrv_ff <= 1'b0;
  end
  assign link.ack = ack_ff;
  assign link.rdata = rdata_ff;
  assign link.rdrv = rdrv_ff;
  // ----------------------------------------
  // Retrace counting for blink
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      vr_sync_ff <= 3'h0;
    else
      vr_sync_ff <= {vr_sync_ff[1:0], vretrace_i};
  end

  // Retrace counts once the last two stages agree high after agreeing low
  assign vr_rise = vr_sync_ff[2:1] == 2'b11 && !vr_rise_seen_ff;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      frame_cnt_ff <= 7'h00;
    else if (vr_rise)
      frame_cnt_ff <= frame_cnt_ff + 7'h01;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      vr_rise_seen_ff <= 1'b0;
    else if (vr_sync_ff[2:1] == 2'b11)
      vr_rise_seen_ff <= 1'b1;
    else if (vr_sync_ff[2:1] == 2'b00)
      vr_rise_seen_ff <= 1'b0;
  end
  assign rate = pixel_path_control_ff[pmt_pkg::CTRL_RATE_LSB +: 2];
  always_comb
  begin
    case (rate)
      pmt_pkg::RATE_16_48: blink_on = (frame_cnt_ff & pmt_pkg::MOD_64) < pmt_pkg::ON_16;
      pmt_pkg::RATE_16_16: blink_on = (frame_cnt_ff & pmt_pkg::MOD_32) < pmt_pkg::ON_16;
      pmt_pkg::RATE_32_32: blink_on = (frame_cnt_ff & pmt_pkg::MOD_64) < pmt_pkg::ON_32;
      default: blink_on = (frame_cnt_ff & pmt_pkg::MOD_128) < pmt_pkg::ON_64;
    endcase
  end
  // ----------------------------------------
  // Pixel path gating
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      index_ff <= 8'h00;
    else
      index_ff <= pixel_index_planes_i & plane_read_mask_ff
        & ~(blink_on ? 8'h00 : plane_blink_mask_ff);
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ov1_ff <= 1'b0;
      ov0_ff <= 1'b0;
    end
    else
    begin
      ov1_ff <= overlay_plane1_in_i && pixel_path_control_ff[pmt_pkg::CTRL_OV1_SHOW]
        && !(pixel_path_control_ff[pmt_pkg::CTRL_OV1_BLINK] && !blink_on);
      ov0_ff <= overlay_plane0_in_i && pixel_path_control_ff[pmt_pkg::CTRL_OV0_SHOW]
        && !(pixel_path_control_ff[pmt_pkg::CTRL_OV0_BLINK] && !blink_on);
    end
  end

  assign palette_index_o = index_ff;
  assign overlay1_o = ov1_ff;
  assign overlay0_o = ov0_ff;
endmodule

// ---- src/pmt_host.sv ----
`timescale 1ns/1ps
module pmt_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pixel source hold request
  output logic pixel_freeze_o,
  // Bus link
  pmt_link_if.host link
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} pmt_host_st_type;
  pmt_host_st_type state_ff;
  logic req_rd_ff;
  logic req_wr_ff;
  logic [2:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic hold_ff;
  logic driven_ff;
  logic dev_hit;
  logic [7:0] onehot;

  assign dev_hit = avs_address <= pmt_pkg::AV_DEV_LAST && avs_address[1:0] == 2'h0;
  // One colour enable at most reaches the device
  assign onehot = {avs_writedata[7:3], avs_writedata[2:0] & (~avs_writedata[2:0] + 3'h1)};
  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= ST_IDLE;
      req_rd_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      addr_ff <= 3'h0;
      wdata_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
      driven_ff <= 1'b0;
      hold_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if ((avs_read || avs_write) && dev_hit)
          begin
            state_ff <= ST_WAIT;
            req_rd_ff <= avs_read;
            req_wr_ff <= avs_write;
            addr_ff <= avs_address[4:2];
            if (avs_address[4:2] == pmt_pkg::ADDR_PROBE)
              wdata_ff <= onehot;
            else
              wdata_ff <= avs_writedata[7:0];
          end
          else if (avs_read || avs_write)
          begin
            state_ff <= ST_DONE;
            if (avs_write && avs_address == pmt_pkg::AV_HOLD)
              hold_ff <= avs_writedata[0];
            if (avs_address == pmt_pkg::AV_STATUS)
              rdata_ff <= {30'h0000_0000, pixel_freeze_o, driven_ff};
            else if (avs_address == pmt_pkg::AV_HOLD)
              rdata_ff <= {31'h0000_0000, hold_ff};
            else
              rdata_ff <= 32'h0000_0000;
          end
        end
        ST_WAIT:
        begin
          if (link.ack)
          begin
            state_ff <= ST_DONE;
            req_rd_ff <= 1'b0;
            req_wr_ff <= 1'b0;
            rdata_ff <= {24'h00_0000, link.rdata};
            if (req_rd_ff)
              driven_ff <= link.rdrv;
          end
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && state_ff != ST_DONE;
  assign avs_readdata = rdata_ff;
  assign pixel_freeze_o = req_rd_ff && addr_ff == pmt_pkg::ADDR_PROBE;
  assign link.sel_n = !(req_rd_ff || req_wr_ff || hold_ff);
  assign link.rd = req_rd_ff;
  assign link.wr = req_wr_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wdata_ff;
endmodule

// ---- verif/pmt_link_assertions.sv ----
`timescale 1ns/1ps
module pmt_link_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Link signals
  input wire logic sel_n,
  input wire logic rd,
  input wire logic wr,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rdrv,
  input wire logic ack
);
  // ----------------------------------------
  // Request tracking
  // ----------------------------------------
  logic busy_ff;
  logic rd_ff;
  logic wr_ff;
  logic [2:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [3:0] known_ff;
  logic [7:0] shadow_ff [4];
  logic take;
  logic wr_done;
  assign take = !sel_n && (rd || wr) && !busy_ff;
  assign wr_done = ack && wr_ff && (addr_ff < pmt_pkg::ADDR_PAL);
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      busy_ff <= 1'b0;
    end
    else if (take)
    begin
      busy_ff <= 1'b1;
    end
    else if (!rd && !wr)
    begin
      busy_ff <= 1'b0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    rd_ff <= rd;
    wr_ff <= wr;
    addr_ff <= addr;
    wdata_ff <= wdata;
  end
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      known_ff <= 4'h0;
    end
    else if (wr_done)
    begin
      known_ff[addr_ff[1:0]] <= 1'b1;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (wr_done)
    begin
      shadow_ff[addr_ff[1:0]] <= wdata_ff;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  sequence s_reg_read(logic [2:0] a);
    ack && rd_ff && (addr_ff == a);
  endsequence
  a_ack_after_take: assert property (take |=> s_answer)
    else $error("ack missing after request");
  a_ack_needs_req: assert property (ack |-> !$past(sel_n) && (rd_ff || wr_ff))
    else $error("ack without request");
  a_ctrl_readback: assert property (s_reg_read(pmt_pkg::ADDR_CTRL) ##0 known_ff[0]
    |-> rdata == shadow_ff[0])
    else $error("control readback wrong");
  a_rmask_readback: assert property (s_reg_read(pmt_pkg::ADDR_RMASK) ##0 known_ff[1]
    |-> rdata == shadow_ff[1])
    else $error("read mask readback wrong");
  a_bmask_readback: assert property (s_reg_read(pmt_pkg::ADDR_BMASK) ##0 known_ff[2]
    |-> rdata == shadow_ff[2])
    else $error("blink mask readback wrong");
  a_probe_low_echo: assert property (s_reg_read(pmt_pkg::ADDR_PROBE) ##0 known_ff[3]
    |-> rdata[3:0] == shadow_ff[3][3:0])
    else $error("probe low nibble wrong");
  a_reg_read_drives: assert property (ack && rd_ff && addr_ff != pmt_pkg::ADDR_PAL |-> rdrv)
    else $error("register read not driven");
  a_rdata_holds: assert property (!ack |-> $stable(rdata) && $stable(rdrv))
    else $error("read data moved without ack");
endmodule

// ---- verif/palette_mask_and_test_regs_tb_top.sv ----
`timescale 1ns/1ps
module palette_mask_and_test_regs_tb_top;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic srst_i;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic vretrace;
  logic [7:0] pix;
  logic ov1_in;
  logic ov0_in;
  logic [7:0] pal_idx;
  logic ov1_out;
  logic ov0_out;
  logic [7:0] dac_r;
  logic [7:0] dac_g;
  logic [7:0] dac_b;
  logic [7:0] pal_wd;
  logic pal_wr;
  logic pal_rd;
  logic freeze;
  int error_cnt = 0;
  int cmp_count = 0;
  int frames = 0;
  int pal_wr_cnt = 0;
  int pal_rd_cnt = 0;
  int freeze_cnt = 0;
  pmt_link_if link ();
  always #2.5 clk_i = ~clk_i;
  pmt_host u_pmt_host (.clk_i(clk_i), .srst_i(srst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pixel_freeze_o(freeze), .link(link));
  pmt_dev u_pmt_dev (.clk_i(clk_i), .srst_i(srst_i), .link(link), .vretrace_i(vretrace),
    .pixel_index_planes_i(pix), .overlay_plane1_in_i(ov1_in), .overlay_plane0_in_i(ov0_in),
    .palette_index_o(pal_idx), .overlay1_o(ov1_out), .overlay0_o(ov0_out),
    .dac_red_i(dac_r), .dac_green_i(dac_g), .dac_blue_i(dac_b),
    .pal_wr_o(pal_wr), .pal_rd_o(pal_rd), .pal_wdata_o(pal_wd));
  pmt_link_assertions u_pmt_link_assertions (.clk_i(clk_i), .srst_i(srst_i),
    .sel_n(link.sel_n), .rd(link.rd), .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .rdrv(link.rdrv), .ack(link.ack));
  // Pulse and hold counters
  always @(posedge clk_i)
  begin
    if (pal_wr === 1'b1)
      pal_wr_cnt++;
    if (pal_rd === 1'b1)
      pal_rd_cnt++;
    if (freeze === 1'b1)
      freeze_cnt++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      error_cnt++;
      $display("unexpected at %0t waitrequest got %h exp %h", $time, 1'b1, 1'b0);
      report_and_stop();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      vretrace <= 1'b1;
      repeat (4) @(posedge clk_i);
      vretrace <= 1'b0;
      repeat (3) @(posedge clk_i);
      frames++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs;
    logic [7:0] q;
    wreg(6'h04, 8'hA5);
    wreg(6'h08, 8'h3C);
    wreg(6'h00, 8'h5A);
    xfer(1'b0, 6'h04, 8'h00, q);
    chk8(q, 8'hA5);
    xfer(1'b0, 6'h08, 8'h00, q);
    chk8(q, 8'h3C);
    xfer(1'b0, 6'h00, 8'h00, q);
    chk8(q, 8'h5A);
    xfer(1'b0, 6'h30, 8'h00, q);
    chk8(q, 8'h00);
    wreg(6'h24, 8'h01);
    xfer(1'b0, 6'h24, 8'h00, q);
    chk8(q, 8'h01);
    wreg(6'h24, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_probe;
    logic [7:0] q;
    logic [7:0] wv [5] = '{8'hF9, 8'h02, 8'h04, 8'h0C, 8'h07};
    logic [7:0] ev [5] = '{8'hC9, 8'h72, 8'hB4, 8'h3C, 8'h51};
    for (int i = 0; i < 5; i++)
    begin
      wreg(6'h0C, wv[i]);
      xfer(1'b0, 6'h0C, 8'h00, q);
      chk8(q, ev[i]);
    end
    chk8(freeze_cnt[7:0], 8'h0A);
    $display("test probe done");
  endtask
  task automatic test_palette;
    logic [7:0] q;
    wreg(6'h10, 8'h96);
    xfer(1'b0, 6'h10, 8'h00, q);
    @(negedge clk_i);
    chk8(pal_wd, 8'h96);
    chk8(pal_wr_cnt[7:0], 8'h01);
    chk8(pal_rd_cnt[7:0], 8'h01);
    xfer(1'b0, 6'h20, 8'h00, q);
    chk8(q, 8'h01);
    $display("test palette done");
  endtask
  task automatic test_gate;
    wreg(6'h04, 8'hA5);
    pix <= 8'h3C;
    ov1_in <= 1'b1;
    ov0_in <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wreg(6'h00, c[7:0]);
      repeat (4) @(negedge clk_i);
      chk8(pal_idx, 8'h24);
      chk8({6'h00, ov1_out, ov0_out}, c[7:0]);
    end
    $display("test gate done");
  endtask
  task automatic test_blink;
    int on_t [4] = '{16, 16, 32, 64};
    int mod_t [4] = '{63, 31, 63, 127};
    logic ph;
    wreg(6'h04, 8'h0F);
    wreg(6'h08, 8'h83);
    pix <= 8'hFF;
    for (int r = 0; r < 4; r++)
    begin
      wreg(6'h00, {2'h0, r[1:0], 4'hF});
      for (int k = 0; k < 4; k++)
      begin
        pulse(13);
        repeat (8) @(negedge clk_i);
        ph = (frames & mod_t[r]) < on_t[r];
        chk8(pal_idx, ph ? 8'h0F : 8'h0C);
        chk8({6'h00, ov1_out, ov0_out}, ph ? 8'h03 : 8'h00);
      end
    end
    $display("test blink done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    srst_i = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    vretrace = 1'b0;
    pix = 8'h00;
    ov1_in = 1'b0;
    ov0_in = 1'b0;
    dac_r = 8'h5C;
    dac_g = 8'h7E;
    dac_b = 8'hB3;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    test_regs();
    test_probe();
    test_palette();
    test_gate();
    test_blink();
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
